// ===== common/hlt_pkg.sv
// package for the hardware-limit timer: register map, field layout,
// reset values and carrier types shared by the timer and its bus slave.
// assumes a 32-bit AXI4-Lite register bus with byte addresses.
package hlt_pkg;
  localparam int CNT_BITS = 8;
  localparam int ADDR_W = 8;
  localparam int MODE_W = 5;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_PULSE = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_MODE_LSB = 8;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_ARMED_BIT = 1;
  localparam int STAT_PWM_BIT = 2;

  // reset values
  localparam logic RUN_RST = 1'b0;
  localparam logic [4:0] MODE_RST = 5'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [7:0] PULSE_RST = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    FAM_FREE = 2'b00,
    FAM_ONESHOT = 2'b01,
    FAM_MONO = 2'b10,
    FAM_RSV = 2'b11
  } hlt_fam_t;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } hlt_wr_t;

  typedef struct packed {
    hlt_fam_t fam;
    logic gate;
    logic start;
    logic clr;
    logic hold;
  } hlt_dec_t;
endpackage

// ===== logic/hlt_edge_det.sv
// edge detector for the external reset/gate signal.
// assumes the signal is already synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module hlt_edge_det
  import hlt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  // signal
  input wire logic sigIn,
  output logic rise,
  output logic fall
);
  logic prevQ;

  // low after reset, so a signal already high reads as a rising edge
  always_ff @(posedge clk) begin
    if (reset) begin
      prevQ <= 1'b0;
    end else if (clkEn) begin
      prevQ <= sigIn;
    end
  end

  assign rise = sigIn & ~prevQ;
  assign fall = ~sigIn & prevQ;
endmodule // hlt_edge_det
`default_nettype wire

// ===== logic/hlt_axil_slave.sv
// AXI4-Lite slave front end: holds write address and data, issues one
// write strobe, and registers read data from the caller's mux.
// assumes the caller decodes addresses combinationally.
`timescale 1ns/100ps
`default_nettype none
module hlt_axil_slave
  import hlt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  // AXI4-Lite
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  output hlt_wr_t wr,
  input wire logic wrErr,
  output logic [ADDR_W-1:0] rdAddr,
  output logic rdEn,
  input wire logic [31:0] rdData,
  input wire logic rdErr
);
  logic awHeldQ, wHeldQ;
  logic [ADDR_W-1:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  wire logic awTake = awvalid & awready;
  wire logic wTake = wvalid & wready;

  assign awready = clkEn & ~awHeldQ;
  assign wready = clkEn & ~wHeldQ;
  assign arready = clkEn & ~rvalid;
  assign rdEn = arvalid & arready;
  assign rdAddr = araddr;
  assign wr.en = clkEn & awHeldQ & wHeldQ & ~bvalid;
  assign wr.addr = awAddrQ;
  assign wr.data = wDataQ;
  assign wr.strb = wStrbQ;

  always_ff @(posedge clk) begin
    if (reset) begin
      awHeldQ <= 1'b0;
      wHeldQ <= 1'b0;
    end else if (clkEn) begin
      awHeldQ <= wr.en ? 1'b0 : (awHeldQ | awTake);
      wHeldQ <= wr.en ? 1'b0 : (wHeldQ | wTake);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      awAddrQ <= '0;
      wDataQ <= '0;
      wStrbQ <= '0;
    end else if (clkEn) begin
      if (awTake) awAddrQ <= awaddr;
      if (wTake) wDataQ <= wdata;
      if (wTake) wStrbQ <= wstrb;
    end
  end

  // write answer one edge after both halves are held
  always_ff @(posedge clk) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (clkEn) begin
      if (wr.en) begin
        bvalid <= 1'b1;
        bresp <= wrErr ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (clkEn) begin
      if (rdEn) begin
        rvalid <= 1'b1;
        rdata <= rdData;
        rresp <= rdErr ? RESP_SLVERR : RESP_OKAY;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule // hlt_axil_slave
`default_nettype wire

// ===== logic/hlt_timer.sv
// hardware-limit timer with five-bit mode control, period match and
// pulse-width output, reached over AXI4-Lite.
// assumes extResetSignal is synchronous to clk; clkEn is the timer tick.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - mode 00000: run bit alone gates counting
// - modes 00001/00010: count while signal high/low
// - modes 00011-00101: any/rising/falling edge clears count
// - modes 00110/00111: signal low/high holds count reset
// - mode 01000: one-shot starts on run bit
// - modes 01001-01011: one-shot rising/falling/any edge start
// - modes 01100/01101: edge both starts and resets
// - modes 01110/01111: edge start, opposite level holds reset
// - one-shot match: next clock clears run, count 00h
// - modes 10001-10011: monostable rising/falling/any edge start
// - monostable match: count 00h, run bit stays
// - modes 10110/10111: level start, opposite level reset
// - edge modes need fresh edge after run set
// - level-reset one-shot counts from reset-to-active transition
// - rerun after clear waits for new edge
// - pwm goes active on starting edge
// - pwm inactive at compare, reactivated at wrap only in free modes
module hlt_timer
  import hlt_pkg::*;
#(
  parameter int CNT_W = CNT_BITS
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  // AXI4-Lite register bus
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // timer pins
  input wire logic extResetSignal,
  output logic pwmOut,
  output logic [CNT_W-1:0] countValue,
  output logic timerRunning
);
  function automatic logic hitAddr(input logic [ADDR_W-1:0] a);
    return (a == OFS_CTRL) || (a == OFS_PERIOD) || (a == OFS_PULSE) ||
           (a == OFS_COUNT) || (a == OFS_STATUS);
  endfunction

  // start/reset/gate terms for each mode
  function automatic hlt_dec_t decodeMode(input logic [4:0] m,
                                          input logic ext,
                                          input logic rise,
                                          input logic fall);
    hlt_dec_t d;
    logic edgeSel;
    d = '{fam: FAM_RSV, gate: 1'b0, start: 1'b0, clr: 1'b0, hold: 1'b0};
    case (m[2:0])
      3'h1, 3'h4, 3'h6: edgeSel = rise;
      3'h2, 3'h5, 3'h7: edgeSel = fall;
      3'h3: edgeSel = rise | fall;
      default: edgeSel = 1'b1;
    endcase
    case (m[4:3])
      2'b00: begin
        d.fam = FAM_FREE;
        case (m[2:0])
          3'h1: d.gate = ext;
          3'h2: d.gate = ~ext;
          3'h6: d.gate = ext;
          3'h7: d.gate = ~ext;
          default: d.gate = 1'b1;
        endcase
        case (m[2:0])
          3'h3: d.clr = rise | fall;
          3'h4: d.clr = rise;
          3'h5: d.clr = fall;
          3'h6: d.clr = ~ext;
          3'h7: d.clr = ext;
          default: d.clr = 1'b0;
        endcase
      end
      2'b01: begin
        d.fam = FAM_ONESHOT;
        d.start = edgeSel;
        case (m[2:0])
          3'h4: d.clr = rise;
          3'h5: d.clr = fall;
          default: d.clr = 1'b0;
        endcase
        case (m[2:0])
          3'h6: d.hold = ~ext;
          3'h7: d.hold = ext;
          default: d.hold = 1'b0;
        endcase
      end
      2'b10: begin
        case (m[2:0])
          3'h1, 3'h2, 3'h3: begin
            d.fam = FAM_MONO;
            d.start = edgeSel;
          end
          3'h6: begin
            d.fam = FAM_ONESHOT;
            d.start = ext;
            d.hold = ~ext;
          end
          3'h7: begin
            d.fam = FAM_ONESHOT;
            d.start = ~ext;
            d.hold = ext;
          end
          default: d.fam = FAM_RSV;
        endcase
      end
      default: d.fam = FAM_RSV;
    endcase
    return d;
  endfunction

  hlt_wr_t wr;
  hlt_dec_t dec;
  logic [ADDR_W-1:0] rdAddr;
  logic [31:0] rdData;
  logic extRise, extFall;
  logic runQ, runD, armedQ, armedD, pwmQ, pwmD;
  logic [4:0] modeQ;
  logic [CNT_W-1:0] periodValueQ, pulseWidthValueQ, countQ, countD;

  hlt_axil_slave u_bus (
    .clk(clk),
    .reset(reset),
    .clkEn(clkEn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr(wr),
    .wrErr(~hitAddr(wr.addr)),
    .rdAddr(rdAddr),
    .rdEn(),
    .rdData(rdData),
    .rdErr(~hitAddr(rdAddr))
  );

  hlt_edge_det u_edge (
    .clk(clk),
    .reset(reset),
    .clkEn(clkEn),
    .sigIn(extResetSignal),
    .rise(extRise),
    .fall(extFall)
  );

  // register writes: run in byte 0, mode in byte 1
  wire logic ctrlWr = wr.en && (wr.addr == OFS_CTRL);
  wire logic runWr = ctrlWr & wr.strb[0];
  wire logic modeWr = ctrlWr & wr.strb[1];
  wire logic periodWr = wr.en && (wr.addr == OFS_PERIOD) && wr.strb[0];
  wire logic pulseWr = wr.en && (wr.addr == OFS_PULSE) && wr.strb[0];

  // mode decode and counting terms
  assign dec = decodeMode(modeQ, extResetSignal, extRise, extFall);
  wire logic isFree = dec.fam == FAM_FREE;
  wire logic isOs = dec.fam == FAM_ONESHOT;
  wire logic isMono = dec.fam == FAM_MONO;
  wire logic isRsv = dec.fam == FAM_RSV;
  wire logic lvlPwm = modeQ[4:1] == 4'b0111;
  wire logic edgeMode = isMono || (modeQ[4:3] == 2'b01 && modeQ[2:0] != 3'h0);
  wire logic counting = ~isRsv & runQ & (isFree ? dec.gate : (armedQ & ~dec.hold));
  wire logic atPeriod = countQ == periodValueQ;
  wire logic wrapEv = counting & atPeriod;
  wire logic atPulse = countQ == pulseWidthValueQ;
  wire logic armSet = armedD & ~armedQ;

  // reserved modes freeze; clears win over increment
  assign countD = isRsv ? countQ :
                  (dec.clr | dec.hold) ? '0 :
                  wrapEv ? '0 :
                  counting ? CNT_W'(countQ + 1'b1) : countQ;

  // armed only by a start seen while run is set
  assign armedD = (isFree | isRsv | ~runQ | dec.hold) ? 1'b0 :
                  wrapEv ? 1'b0 :
                  dec.start ? 1'b1 : armedQ;

  // software write wins over the hardware clear
  assign runD = runWr ? wr.data[CTRL_RUN_BIT] :
                (wrapEv & isOs) ? 1'b0 : runQ;

  // free modes start the pulse at wrap, others at the starting edge
  assign pwmD = ((armSet & ~isFree) | (wrapEv & isFree)) ? 1'b1 :
                atPulse ? 1'b0 : pwmQ;

  always_ff @(posedge clk) begin
    if (reset) begin
      runQ <= RUN_RST;
      modeQ <= MODE_RST;
      periodValueQ <= CNT_W'(PERIOD_RST);
      pulseWidthValueQ <= CNT_W'(PULSE_RST);
    end else if (clkEn) begin
      runQ <= runD;
      if (modeWr) modeQ <= wr.data[CTRL_MODE_LSB +: MODE_W];
      if (periodWr) periodValueQ <= wr.data[CNT_W-1:0];
      if (pulseWr) pulseWidthValueQ <= wr.data[CNT_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      countQ <= '0;
      armedQ <= 1'b0;
      pwmQ <= 1'b0;
    end else if (clkEn) begin
      countQ <= countD;
      armedQ <= armedD;
      pwmQ <= pwmD;
    end
  end

  // read mux
  wire logic [31:0] ctrlRd = {19'h0, modeQ, 7'h0, runQ};
  wire logic [31:0] statRd = {29'h0, pwmQ, armedQ, runQ};
  assign rdData = (rdAddr == OFS_CTRL) ? ctrlRd :
                  (rdAddr == OFS_PERIOD) ? 32'(periodValueQ) :
                  (rdAddr == OFS_PULSE) ? 32'(pulseWidthValueQ) :
                  (rdAddr == OFS_COUNT) ? 32'(countQ) :
                  (rdAddr == OFS_STATUS) ? statRd : 32'h0;

  assign countValue = countQ;
  assign pwmOut = pwmQ;
  assign timerRunning = counting;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence runOffEdge_s;
    clkEn && !runQ && edgeMode;
  endsequence
  sequence runOnQuiet_s;
    clkEn && runQ && !dec.start && $stable(modeQ);
  endsequence

  resv_hold_a: assert property (clkEn && isRsv |=> $stable(countQ))
    else $error("count moved in reserved mode");
  sw_gate_a: assert property (
    clkEn && modeQ == 5'h00 && runQ && !atPeriod |=> countQ == CNT_W'($past(countQ) + 1'b1))
    else $error("software-gated count did not step");
  hw_gate_a: assert property (
    clkEn && modeQ == 5'h01 && !extResetSignal |=> $stable(countQ))
    else $error("gated count moved while signal low");
  edge_clr_a: assert property (clkEn && modeQ == 5'h04 && extRise |=> countQ == '0)
    else $error("rising edge did not clear count");
  lvl_hold_a: assert property (
    clkEn && modeQ == 5'h06 && !extResetSignal |=> countQ == '0)
    else $error("low level did not hold count reset");
  one_stop_a: assert property (
    clkEn && wrapEv && isOs && !runWr |=> countQ == '0 && !runQ)
    else $error("one-shot did not stop after match");
  mono_keep_a: assert property (
    clkEn && wrapEv && isMono && !runWr |=> countQ == '0 && runQ && !armedQ)
    else $error("monostable stop wrong after match");
  fresh_edge_a: assert property (runOffEdge_s ##1 runOnQuiet_s |=> !armedQ)
    else $error("counting resumed without fresh edge");
  pwm_on_a: assert property (clkEn && lvlPwm && armSet |=> pwmQ)
    else $error("pwm not active on starting edge");
  pwm_off_a: assert property (
    clkEn && lvlPwm && pwmQ && atPulse && !armSet |=> !pwmQ)
    else $error("pwm not cleared at compare");
  pwm_nowrap_a: assert property (
    clkEn && lvlPwm && wrapEv && !pwmQ && !armSet |=> !pwmQ)
    else $error("pwm reactivated at period wrap");
  // the step after the wrap is judged only when that step really counts
  free_wrap_a: assert property (
    clkEn && isFree && wrapEv && !dec.clr |=> countQ == '0 and
      (clkEn && counting && !dec.clr && !atPeriod |=> countQ == CNT_W'(1)))
    else $error("free-running wrap wrong");
endmodule // hlt_timer
`default_nettype wire

// ===== tb/hlt_ext_src.sv
// partner model: the external reset/gate source facing the timer.
// assumes the bench requests a level; it is launched on the next clk edge.
`timescale 1ns/100ps
`default_nettype none
module hlt_ext_src (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // level request and pin
  input wire logic lvlReq,
  output logic extResetSignal
);
  // launched on the edge so the timer always sees a synchronous level
  always_ff @(posedge clk) begin
    if (reset) begin
      extResetSignal <= 1'b0;
    end else begin
      extResetSignal <= lvlReq;
    end
  end
endmodule // hlt_ext_src
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the hardware-limit timer.
// assumes hlt_pkg, the timer and the partner model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import hlt_pkg::*;
  logic clk, reset, clkEn, lvlReq, extResetSignal, pwmOut, timerRunning;
  logic awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
  logic awready, wready, arready;
  logic [7:0] awaddr, araddr, countValue, snap;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [4:0] rsv[4] = '{5'h10, 5'h14, 5'h15, 5'h18};
  int failures, samples_checked, seed, per;

  hlt_ext_src src_u (.clk(clk), .reset(reset), .lvlReq(lvlReq),
    .extResetSignal(extResetSignal));

  hlt_timer dut_u (.clk(clk), .reset(reset), .clkEn(clkEn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .extResetSignal(extResetSignal), .pwmOut(pwmOut),
    .countValue(countValue), .timerRunning(timerRunning));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic stall;
    failures++;
    $display("mismatch t=%0t wait ran out", $time);
    wrap_up();
  endtask

  task automatic cmpBus(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t bus got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmpPin(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t pin got %h exp %h", $time, got, exp);
    end
  endtask

  // answers are judged here, in the order the requests were noted
  always @(posedge clk) begin
    if (bvalid && bready) cmpBus({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid && rready) cmpBus({rresp, rdata}, rq.pop_front());
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 40);
    bready <= 1'b0;
    if (n >= 40) stall();
    #1;
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    rq.push_back({r, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 40);
    rready <= 1'b0;
    if (n >= 40) stall();
    #1;
  endtask

  task automatic waitCnt(input logic [7:0] v);
    int n;
    n = 0;
    while (countValue !== v && n < 600) begin
      tick(1);
      n++;
    end
    if (n >= 600) stall();
  endtask

  function automatic logic [31:0] ctl(input logic [4:0] m, input logic r);
    return {19'h0, m, 7'h0, r};
  endfunction

  initial begin
    seed = 22847;
    reset = 1'b1;
    clkEn = 1'b1;
    lvlReq = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    tick(1);
    axr(OFS_CTRL, 32'h0, RESP_OKAY);
    axr(OFS_PERIOD, 32'hff, RESP_OKAY);
    axr(OFS_PULSE, 32'h0, RESP_OKAY);
    axr(8'h20, 32'h0, RESP_SLVERR);
    axw(8'h20, 32'h5, RESP_SLVERR);
    axw(OFS_COUNT, 32'h7, RESP_OKAY);
    axr(OFS_COUNT, 32'h0, RESP_OKAY);
    // free running; the external level is set once at random and must not matter
    per = 3 + ($random(seed) & 7);
    axw(OFS_PERIOD, 32'(per), RESP_OKAY);
    axw(OFS_CTRL, ctl(5'h00, 1'b1), RESP_OKAY);
    lvlReq <= 1'($random(seed));
    waitCnt(8'(per));
    tick(1);
    cmpPin(countValue, 8'h00);
    tick(1);
    cmpPin(countValue, 8'h01);
    axw(OFS_CTRL, ctl(5'h00, 1'b0), RESP_OKAY);
    snap = countValue;
    tick(4);
    cmpPin(countValue, snap);
    // high gate
    lvlReq <= 1'b0;
    axw(OFS_PERIOD, 32'hff, RESP_OKAY);
    axw(OFS_CTRL, ctl(5'h01, 1'b1), RESP_OKAY);
    snap = countValue;
    tick(5);
    cmpPin(countValue, snap);
    lvlReq <= 1'b1;
    waitCnt(snap + 8'h03);
    // a low enable freezes the running count
    @(posedge clk);
    clkEn <= 1'b0;
    tick(1);
    snap = countValue;
    tick(4);
    cmpPin(countValue, snap);
    @(posedge clk);
    clkEn <= 1'b1;
    // rising edge clears the count
    axw(OFS_CTRL, ctl(5'h04, 1'b1), RESP_OKAY);
    lvlReq <= 1'b0;
    waitCnt(8'h40);
    lvlReq <= 1'b1;
    tick(3);
    cmpPin({7'h0, countValue < 8'h04}, 8'h01);
    // reserved codes freeze the count
    foreach (rsv[i]) begin
      axw(OFS_CTRL, ctl(rsv[i], 1'b1), RESP_OKAY);
      snap = countValue;
      tick(3);
      cmpPin(countValue, snap);
    end
    // low level holds reset
    lvlReq <= 1'b0;
    axw(OFS_CTRL, ctl(5'h06, 1'b1), RESP_OKAY);
    tick(3);
    cmpPin(countValue, 8'h00);
    // one-shot, rising start
    axw(OFS_PERIOD, 32'h3, RESP_OKAY);
    axw(OFS_CTRL, ctl(5'h09, 1'b1), RESP_OKAY);
    lvlReq <= 1'b1;
    waitCnt(8'h03);
    tick(1);
    cmpPin(countValue, 8'h00);
    axr(OFS_CTRL, ctl(5'h09, 1'b0), RESP_OKAY);
    axw(OFS_CTRL, ctl(5'h09, 1'b1), RESP_OKAY);
    tick(6);
    cmpPin({7'h0, timerRunning}, 8'h00);
    cmpPin(countValue, 8'h00);
    lvlReq <= 1'b0;
    tick(2);
    lvlReq <= 1'b1;
    waitCnt(8'h02);
    tick(4);
    // monostable keeps the run bit
    lvlReq <= 1'b0;
    axw(OFS_CTRL, ctl(5'h11, 1'b1), RESP_OKAY);
    lvlReq <= 1'b1;
    waitCnt(8'h03);
    tick(1);
    cmpPin(countValue, 8'h00);
    axr(OFS_CTRL, ctl(5'h11, 1'b1), RESP_OKAY);
    axr(OFS_STATUS, 32'h1, RESP_OKAY);
    lvlReq <= 1'b0;
    tick(2);
    lvlReq <= 1'b1;
    waitCnt(8'h02);
    // level-reset one-shot driving the pulse output
    axw(OFS_PULSE, 32'h2, RESP_OKAY);
    axw(OFS_PERIOD, 32'h5, RESP_OKAY);
    lvlReq <= 1'b0;
    axw(OFS_CTRL, ctl(5'h0e, 1'b1), RESP_OKAY);
    tick(3);
    cmpPin(countValue, 8'h00);
    lvlReq <= 1'b1;
    waitCnt(8'h01);
    cmpPin({7'h0, pwmOut}, 8'h01);
    waitCnt(8'h04);
    cmpPin({7'h0, pwmOut}, 8'h00);
    waitCnt(8'h05);
    tick(3);
    cmpPin({7'h0, pwmOut}, 8'h00);
    cmpPin(countValue, 8'h00);
    // software-started one-shot ignores the external level
    axw(OFS_CTRL, ctl(5'h08, 1'b1), RESP_OKAY);
    waitCnt(8'h05);
    tick(1);
    axr(OFS_CTRL, ctl(5'h08, 1'b0), RESP_OKAY);
    // rising edges both start and clear
    lvlReq <= 1'b0;
    axw(OFS_CTRL, ctl(5'h0c, 1'b1), RESP_OKAY);
    lvlReq <= 1'b1;
    waitCnt(8'h02);
    lvlReq <= 1'b0;
    tick(1);
    lvlReq <= 1'b1;
    tick(3);
    cmpPin(countValue, 8'h01);
    // level start one-shot, low level holds reset
    lvlReq <= 1'b0;
    axw(OFS_CTRL, ctl(5'h16, 1'b1), RESP_OKAY);
    tick(2);
    cmpPin(countValue, 8'h00);
    lvlReq <= 1'b1;
    waitCnt(8'h03);
    lvlReq <= 1'b0;
    tick(2);
    cmpPin(countValue, 8'h00);
    wrap_up();
  end
endmodule // tb
`default_nettype wire
